// *** rtl/fsc_pkg.sv ***
// Purpose: shared constants and decode functions for the frame syndrome checker
// Assumes: frames arrive as 32-bit words, frame bit 0 in bit 0 of the first word
// Notes:   location map and its inverse live here so both ends agree

package fsc_pkg;

  localparam int unsigned FRAME_BITS  = 1312;
  localparam int unsigned WORD_W      = 32;
  localparam int unsigned WORD_SH     = 5;
  localparam int unsigned FRAME_WORDS = FRAME_BITS / WORD_W;
  localparam int unsigned WCNT_W      = 6;
  localparam int unsigned IDX_W       = 11;
  localparam int unsigned LOC_W       = 11;
  localparam int unsigned SYN_W       = 12;
  localparam int unsigned FADDR_W     = 32;
  localparam int unsigned CNT_W       = 16;

  localparam logic [WCNT_W-1:0] LAST_WORD   = 6'h28;
  localparam logic [IDX_W-1:0]  SPLIT_IDX   = 11'h140;
  localparam logic [LOC_W-1:0]  LOC_BASE_LO = 11'h2C0;
  localparam logic [LOC_W-1:0]  LOC_BASE_HI = 11'h2E0;
  localparam logic [IDX_W-1:0]  PAR_FIRST   = 11'h280;
  localparam logic [IDX_W-1:0]  PAR_LAST    = 11'h28A;
  localparam logic [IDX_W-1:0]  PAR_OVERALL = 11'h28B;
  localparam logic [5:0]        COARSE_OFF  = 6'h16;
  localparam int unsigned       OVERALL_BIT = 11;

  typedef enum logic [2:0] {
    FSC_ST_STREAM,
    FSC_ST_FIX,
    FSC_ST_FETCH,
    FSC_ST_LOAD,
    FSC_ST_WRITE
  } fsc_state_type;

  // hamming location of a frame bit; the overall parity bit has no location
  function automatic logic [LOC_W-1:0] fsc_bit_loc(input logic [IDX_W-1:0] idx);
    logic [LOC_W-1:0] loc;
    loc = '0;
    if (idx >= PAR_FIRST && idx <= PAR_LAST)
      loc = LOC_W'(1) << (idx - PAR_FIRST);
    else if (idx == PAR_OVERALL)
      loc = '0;
    else if (idx < SPLIT_IDX)
      loc = idx + LOC_BASE_LO;
    else
      loc = idx + LOC_BASE_HI;
    return loc;
  endfunction

  function automatic logic fsc_is_pow2(input logic [LOC_W-1:0] v);
    return (v != '0) && ((v & (v - LOC_W'(1))) == '0);
  endfunction

  // frame bit index named by a single-error syndrome
  function automatic logic [IDX_W-1:0] fsc_syn_index(input logic [SYN_W-1:0] syn);
    logic [IDX_W-1:0] idx;
    logic [5:0]       coarse;
    idx    = PAR_OVERALL;
    coarse = syn[10:5] - COARSE_OFF - {5'h00, syn[10]};
    if (syn[LOC_W-1:0] == '0)
      idx = PAR_OVERALL;
    else if (fsc_is_pow2(syn[LOC_W-1:0]))
    begin
      for (int k = 0; k < LOC_W; k++)
        if (syn[k])
          idx = PAR_FIRST + IDX_W'(k);
    end
    else
      idx = {coarse, syn[4:0]};
    return idx;
  endfunction

endpackage

// *** rtl/fsc_if.sv ***
// Purpose: link between the syndrome checker and the repair logic
// Assumes: one clock; the checker drives every signal here
// Notes:   the readback words are forwarded so the repair end can store them

`timescale 1ns/1ps

interface fsc_if;
  import fsc_pkg::*;

  logic                 rb_valid;
  logic [WORD_W-1:0]    rb_word;
  logic                 done;
  logic [SYN_W-1:0]     syndrome;
  logic                 error;
  logic                 single_err;
  logic                 double_err;
  logic                 parity_err;
  logic [IDX_W-1:0]     bit_index;

  modport chk (
    output rb_valid, rb_word, done, syndrome, error,
    output single_err, double_err, parity_err, bit_index
  );

  modport rep (
    input rb_valid, rb_word, done, syndrome, error,
    input single_err, double_err, parity_err, bit_index
  );
endinterface

// *** rtl/fsc_checker.sv ***
// Purpose: SECDED syndrome check over each read-back configuration frame
// Assumes: readback words arrive on i_rb_valid, 41 words per frame, no gaps needed
// Notes:   no correction here; results hold from one done strobe to the next
// Behaviour
// - syndrome covers every frame bit, ecc included
// - unchanged frame gives all-zero syndrome
// - single flip sets bit 11, locates bit
// - double flip: bit 11 clear, low bits nonzero
// - over two flips: syndrome means nothing
// - error asserts for one or two flips
// - done pulses one cycle per frame end
// - a frame is 1312 bits, 0 to 1311
// - low bits hamming, bit 11 overall parity
// - bit 11 alone flags overall parity error
// - data locations run 704 to 2047
// - index is location minus 704 or 736
// - index from coarse field minus 22 minus bit10
// - zero or power of two: parity bit
// - hamming parity bits sit at 640-650, overall at 651
// - repair side keeps frame copy or refetches
// - repair side stores frames, tracks frame address
// - on error halt, save, restore or invert
// - write back, then resume at next frame

`timescale 1ns/1ps

module fsc_checker
(
  input  wire logic                      i_core_clk,
  input  wire logic                      i_rst_n,
  input  wire logic                      i_rb_valid,
  input  wire logic [fsc_pkg::WORD_W-1:0] i_rb_word,
  input  wire logic                      i_rb_abort,
  output logic                           o_busy,
  output logic [fsc_pkg::CNT_W-1:0]      o_frames_checked,
  output logic [fsc_pkg::CNT_W-1:0]      o_frames_bad,
  fsc_if.chk                             lnk
);
  import fsc_pkg::*;

  logic [WCNT_W-1:0] word_cnt_ff;
  logic [LOC_W-1:0]  acc_loc_ff;
  logic              acc_par_ff;
  logic [LOC_W-1:0]  word_loc;
  logic              word_par;
  logic [LOC_W-1:0]  term [WORD_W];
  logic [IDX_W-1:0]  idx_base;
  logic [SYN_W-1:0]  nxt_syn;
  logic              last_word;
  logic              frame_end;
  logic              rb_valid_ff;
  logic [WORD_W-1:0] rb_word_ff;
  logic              done_ff;
  logic [SYN_W-1:0]  syn_ff;
  logic              error_ff;
  logic              single_ff;
  logic              double_ff;
  logic              parity_ff;
  logic [IDX_W-1:0]  index_ff;
  logic [CNT_W-1:0]  checked_ff;
  logic [CNT_W-1:0]  bad_ff;

  assign idx_base  = {word_cnt_ff, 5'h00};
  assign last_word = (word_cnt_ff == LAST_WORD);
  assign frame_end = i_rb_valid && last_word && !i_rb_abort;

  // every bit of the word contributes its location when set
  genvar j;
  generate
    for (j = 0; j < WORD_W; j++)
    begin : g_term
      assign term[j] = i_rb_word[j] ? fsc_bit_loc(idx_base + IDX_W'(j)) : '0;
    end
  endgenerate

  // flat xor of the per-bit locations; left to synthesis to balance
  always_comb
  begin
    word_loc = '0;
    for (int k = 0; k < WORD_W; k++)
      word_loc = word_loc ^ term[k];
  end

  // overall parity runs over the parity bits too, so bit 11 sees every flip
  assign word_par = ^i_rb_word;
  // syndrome with this word folded in; on the last word it is the result
  assign nxt_syn  = {acc_par_ff ^ word_par, acc_loc_ff ^ word_loc};

  // position of the next word within the frame
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n || i_rb_abort)
      word_cnt_ff <= '0;
    else if (i_rb_valid)
    begin
      if (last_word)
        word_cnt_ff <= '0;
      else
        word_cnt_ff <= word_cnt_ff + WCNT_W'(1);
    end
  end

  // running syndrome; cleared at each frame end so frames stay independent
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n || i_rb_abort)
    begin
      acc_loc_ff <= '0;
      acc_par_ff <= 1'b0;
    end
    else if (i_rb_valid)
    begin
      if (last_word)
      begin
        acc_loc_ff <= '0;
        acc_par_ff <= 1'b0;
      end
      else
      begin
        acc_loc_ff <= nxt_syn[LOC_W-1:0];
        acc_par_ff <= nxt_syn[OVERALL_BIT];
      end
    end
  end

  // forwarded copy of each word, aligned with done on the last one
  // abort is not passed on, so the repair end's word position is not reset
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      rb_valid_ff <= 1'b0;
      rb_word_ff  <= '0;
    end
    else
    begin
      rb_valid_ff <= i_rb_valid && !i_rb_abort;
      if (i_rb_valid)
        rb_word_ff <= i_rb_word;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
      done_ff <= 1'b0;
    else
      done_ff <= frame_end;
  end

  // results load only at frame end, so they stand still around the strobe
  // strobe and results load on one edge, so results are valid with it
  // beyond two flips the flags may look clean or single; nothing guards that
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      syn_ff    <= '0;
      error_ff  <= 1'b0;
      single_ff <= 1'b0;
      double_ff <= 1'b0;
      parity_ff <= 1'b0;
      index_ff  <= '0;
    end
    else if (frame_end)
    begin
      syn_ff    <= nxt_syn;
      error_ff  <= (nxt_syn != '0);
      single_ff <= nxt_syn[OVERALL_BIT];
      double_ff <= !nxt_syn[OVERALL_BIT] && (nxt_syn[LOC_W-1:0] != '0);
      parity_ff <= nxt_syn[OVERALL_BIT] && ((nxt_syn[LOC_W-1:0] == '0)
                   || fsc_is_pow2(nxt_syn[LOC_W-1:0]));
      index_ff  <= fsc_syn_index(nxt_syn);
    end
  end

  // frame statistics wrap silently; they are for monitoring only
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      checked_ff <= '0;
      bad_ff     <= '0;
    end
    else if (done_ff)
    begin
      checked_ff <= checked_ff + CNT_W'(1);
      if (error_ff)
        bad_ff <= bad_ff + CNT_W'(1);
    end
  end

  assign lnk.rb_valid       = rb_valid_ff;
  assign lnk.rb_word        = rb_word_ff;
  assign lnk.done           = done_ff;
  assign lnk.syndrome       = syn_ff;
  assign lnk.error          = error_ff;
  assign lnk.single_err     = single_ff;
  assign lnk.double_err     = double_ff;
  assign lnk.parity_err     = parity_ff;
  assign lnk.bit_index      = index_ff;
  // busy follows the counter, so it drops on the edge that takes the last word
  assign o_busy             = (word_cnt_ff != '0);
  assign o_frames_checked   = checked_ff;
  assign o_frames_bad       = bad_ff;

endmodule // fsc_checker

// *** rtl/fsc_repair.sv ***
// Purpose: fabric-side frame repair using the checker's results
// Assumes: readback engine stops at a frame boundary while o_rb_halt is high
// Notes:   double errors are repaired from a golden copy fetched on request

`timescale 1ns/1ps

module fsc_repair
(
  input  wire logic                        i_core_clk,
  input  wire logic                        i_rst_n,
  fsc_if.rep                               lnk,
  input  wire logic                        i_addr_load,
  input  wire logic [fsc_pkg::FADDR_W-1:0] i_addr_start,
  output logic                             o_rb_halt,
  output logic [fsc_pkg::FADDR_W-1:0]      o_frame_addr,
  output logic                             o_fetch_req,
  input  wire logic                        i_gold_valid,
  input  wire logic [fsc_pkg::WORD_W-1:0]  i_gold_word,
  output logic                             o_wb_valid,
  output logic [fsc_pkg::WORD_W-1:0]       o_wb_word,
  input  wire logic                        i_wb_ready,
  output logic [fsc_pkg::SYN_W-1:0]        o_saved_syn
);
  import fsc_pkg::*;

  logic [WORD_W-1:0]  frame_mem [FRAME_WORDS];
  fsc_state_type      state_ff;
  logic [WCNT_W-1:0]  widx_ff;
  logic [WCNT_W-1:0]  gidx_ff;
  logic [WCNT_W-1:0]  bidx_ff;
  logic [FADDR_W-1:0] addr_ff;
  logic [SYN_W-1:0]   syn_ff;
  logic [IDX_W-1:0]   fix_idx;
  logic               wb_valid_ff;
  logic [WORD_W-1:0]  wb_word_ff;
  logic               wb_take;
  logic               bad_frame;

  assign fix_idx   = fsc_syn_index(syn_ff);
  assign wb_take   = (state_ff == FSC_ST_WRITE) && wb_valid_ff && i_wb_ready;
  assign bad_frame = lnk.done && lnk.error;

  // local frame copy: readback, golden reload and single-bit patch
  always_ff @(posedge i_core_clk)
  begin
    if (state_ff == FSC_ST_STREAM && lnk.rb_valid)
      frame_mem[widx_ff] <= lnk.rb_word;
    else if (state_ff == FSC_ST_FETCH && i_gold_valid)
      frame_mem[gidx_ff] <= i_gold_word;
    else if (state_ff == FSC_ST_FIX)
      frame_mem[fix_idx[IDX_W-1:WORD_SH]][fix_idx[WORD_SH-1:0]] <=
        ~frame_mem[fix_idx[IDX_W-1:WORD_SH]][fix_idx[WORD_SH-1:0]];
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
      widx_ff <= '0;
    else if (state_ff == FSC_ST_STREAM && lnk.rb_valid)
      widx_ff <= lnk.done ? '0 : widx_ff + WCNT_W'(1);
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
      syn_ff <= '0;
    else if (state_ff == FSC_ST_STREAM && bad_frame)
      syn_ff <= lnk.syndrome;
  end

  // frame address follows readback; held across a repair
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
      addr_ff <= '0;
    else if (i_addr_load && state_ff == FSC_ST_STREAM)
      addr_ff <= i_addr_start;
    else if (state_ff == FSC_ST_STREAM && lnk.done && !lnk.error)
      addr_ff <= addr_ff + FADDR_W'(1);
    else if (wb_take && bidx_ff == LAST_WORD)
      addr_ff <= addr_ff + FADDR_W'(1);
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
      state_ff <= FSC_ST_STREAM;
    else
    begin
      case (state_ff)
        FSC_ST_STREAM:
          if (bad_frame)
            state_ff <= lnk.syndrome[OVERALL_BIT] ? FSC_ST_FIX : FSC_ST_FETCH;
        FSC_ST_FIX:
          state_ff <= FSC_ST_LOAD;
        FSC_ST_FETCH:
          if (i_gold_valid && gidx_ff == LAST_WORD)
            state_ff <= FSC_ST_LOAD;
        FSC_ST_LOAD:
          state_ff <= FSC_ST_WRITE;
        FSC_ST_WRITE:
          if (wb_take && bidx_ff == LAST_WORD)
            state_ff <= FSC_ST_STREAM;
        default:
          state_ff <= FSC_ST_STREAM;
      endcase
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n || state_ff != FSC_ST_FETCH)
      gidx_ff <= '0;
    else if (i_gold_valid)
      gidx_ff <= gidx_ff + WCNT_W'(1);
  end

  // write-back stream; LOAD gives the patched word a cycle to settle
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      bidx_ff     <= '0;
      wb_valid_ff <= 1'b0;
      wb_word_ff  <= '0;
    end
    else if (state_ff == FSC_ST_LOAD)
    begin
      bidx_ff     <= '0;
      wb_valid_ff <= 1'b1;
      wb_word_ff  <= frame_mem[0];
    end
    else if (wb_take)
    begin
      if (bidx_ff == LAST_WORD)
        wb_valid_ff <= 1'b0;
      else
      begin
        bidx_ff    <= bidx_ff + WCNT_W'(1);
        wb_word_ff <= frame_mem[bidx_ff + WCNT_W'(1)];
      end
    end
  end

  assign o_rb_halt    = (state_ff != FSC_ST_STREAM) || bad_frame;
  assign o_frame_addr = addr_ff;
  assign o_fetch_req  = (state_ff == FSC_ST_FETCH);
  assign o_wb_valid   = wb_valid_ff;
  assign o_wb_word    = wb_word_ff;
  assign o_saved_syn  = syn_ff;

endmodule // fsc_repair

// *** dv/fsc_monitor.sv ***
// Purpose: concurrent checks on the checker-to-repair link
// Assumes: one clock, synchronous active-low reset
// Notes:   sees link signals only, so abort effects are left to the bench
`timescale 1ns/1ps
module fsc_monitor
(
  input  wire logic                       i_core_clk,
  input  wire logic                       i_rst_n,
  input  wire logic                       rb_valid,
  input  wire logic [fsc_pkg::WORD_W-1:0] rb_word,
  input  wire logic                       done,
  input  wire logic [fsc_pkg::SYN_W-1:0]  syndrome,
  input  wire logic                       error,
  input  wire logic                       single_err,
  input  wire logic                       double_err,
  input  wire logic                       parity_err,
  input  wire logic [fsc_pkg::IDX_W-1:0]  bit_index
);
  import fsc_pkg::*;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  logic [10:0] low;
  logic        p2z;
  assign low = syndrome[10:0];
  // zero counts too: that is the overall parity bit
  assign p2z = (low & (low - 11'h001)) == 11'h000;
  sequence s_strobe;
    done ##1 !done;
  endsequence
  sequence s_hold;
    $stable(syndrome) && $stable(error) && $stable(bit_index);
  endsequence
  a_done_one_cycle: assert property (done |-> s_strobe)
    else $error("done strobe longer than one cycle");
  a_done_last_word: assert property (done |-> rb_valid)
    else $error("done without the last word");
  a_results_hold: assert property (!done |-> s_hold)
    else $error("results moved between strobes");
  a_error_flag: assert property (done |-> error == (syndrome != 12'h000))
    else $error("error flag wrong");
  a_single_flag: assert property (done |-> single_err == syndrome[11])
    else $error("single flag wrong");
  a_double_flag: assert property (done |-> double_err == (!syndrome[11] && low != 11'h000))
    else $error("double flag wrong");
  a_parity_flag: assert property (done |-> parity_err == (syndrome[11] && p2z))
    else $error("parity flag wrong");
  a_index_map: assert property (done && single_err && !parity_err |-> low >= 11'h2C0 &&
    bit_index == ((low < 11'h400) ? low - 11'h2C0 : low - 11'h2E0))
    else $error("bit index wrong");
  a_overall_index: assert property (done && syndrome == 12'h800 |-> bit_index == 11'h28B)
    else $error("overall parity index wrong");
endmodule // fsc_monitor

// *** dv/tb_top.sv ***
// Purpose: end-to-end bench, checker feeding repair through the link
// Assumes: readback stops at frame boundaries while halt is high
// Notes:   expected syndromes come from a local location map
`timescale 1ns/1ps
module tb_top;
  import fsc_pkg::*;
  logic i_core_clk = 1'b0, i_rst_n = 1'b0, i_rb_valid = 1'b0, i_rb_abort = 1'b0;
  logic i_addr_load = 1'b0, i_gold_valid = 1'b0, i_wb_ready = 1'b0;
  logic [WORD_W-1:0]  i_rb_word = '0, i_gold_word = '0, o_wb_word;
  logic [FADDR_W-1:0] i_addr_start = '0, o_frame_addr;
  logic [CNT_W-1:0]   o_frames_checked, o_frames_bad;
  logic [SYN_W-1:0]   o_saved_syn;
  logic o_busy, o_rb_halt, o_fetch_req, o_wb_valid;
  logic [FRAME_BITS-1:0] gold;
  logic [LOC_W-1:0]      h;
  int n_fail = 0;
  int n_checks = 0;
  int ca[12] = '{-1, 0, 319, 320, 639, 652, 1311, 640, 650, 651, 5, 645};
  int cb[12] = '{-1, -1, -1, -1, -1, -1, -1, -1, -1, -1, 700, 1000};
  always #5 i_core_clk = ~i_core_clk;
  fsc_if lnk();
  fsc_checker i_fsc_checker (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_rb_valid(i_rb_valid), .i_rb_word(i_rb_word), .i_rb_abort(i_rb_abort),
    .o_busy(o_busy), .o_frames_checked(o_frames_checked), .o_frames_bad(o_frames_bad),
    .lnk(lnk));
  fsc_repair i_fsc_repair (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .lnk(lnk),
    .i_addr_load(i_addr_load), .i_addr_start(i_addr_start), .o_rb_halt(o_rb_halt),
    .o_frame_addr(o_frame_addr), .o_fetch_req(o_fetch_req), .i_gold_valid(i_gold_valid),
    .i_gold_word(i_gold_word), .o_wb_valid(o_wb_valid), .o_wb_word(o_wb_word),
    .i_wb_ready(i_wb_ready), .o_saved_syn(o_saved_syn));
  fsc_monitor i_fsc_monitor (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .rb_valid(lnk.rb_valid), .rb_word(lnk.rb_word), .done(lnk.done),
    .syndrome(lnk.syndrome), .error(lnk.error), .single_err(lnk.single_err),
    .double_err(lnk.double_err), .parity_err(lnk.parity_err), .bit_index(lnk.bit_index));
  function automatic logic [LOC_W-1:0] loc(input int i);
    if (i >= 640 && i <= 650)
      return 11'h001 << (i - 640);
    if (i == 651)
      return 11'h000;
    return (i < 320) ? LOC_W'(i + 704) : LOC_W'(i + 736);
  endfunction
  task automatic chk(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'b1)
    begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic final_report();
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // words go back to back; returns at the negedge where done should stand
  task automatic send(input logic [FRAME_BITS-1:0] f, input int nw);
    for (int w = 0; w < nw; w++)
    begin
      @(negedge i_core_clk);
      i_rb_valid = 1'b1;
      i_rb_word = f[w*WORD_W +: WORD_W];
    end
    @(negedge i_core_clk);
    i_rb_valid = 1'b0;
  endtask
  // one frame with flips at a and b (-1 for none), then serve the repair
  task automatic run(input int a, input int b);
    logic [FRAME_BITS-1:0] f;
    logic [SYN_W-1:0]      es;
    logic [FADDR_W-1:0]    ad;
    int nw, ng, cyc;
    f = gold;
    es = '0;
    ad = o_frame_addr;
    nw = 0;
    ng = 0;
    cyc = 0;
    if (a >= 0)
    begin
      f[a] = ~f[a];
      es = {1'b1, loc(a)};
    end
    if (b >= 0)
    begin
      f[b] = ~f[b];
      es = {1'b0, loc(a) ^ loc(b)};
    end
    send(f, FRAME_WORDS);
    chk(lnk.done === 1'b1, "no done at frame end");
    chk(lnk.syndrome === es, "syndrome");
    chk(lnk.error === (es != '0), "error flag");
    chk(o_rb_halt === (es != '0), "halt");
    if (a >= 0 && b < 0)
      chk(lnk.bit_index === IDX_W'(a), "bit index");
    chk(lnk.double_err === (b >= 0), "double flag");
    chk(lnk.single_err === (a >= 0 && b < 0), "single flag");
    chk(lnk.parity_err === (a >= 640 && a <= 651 && b < 0), "parity flag");
    while (es != '0 && nw < FRAME_WORDS && cyc < 600)
    begin
      // stall the write-back now and then; a word counts when the next edge takes it
      i_wb_ready = (cyc % 4 != 1);
      if (o_wb_valid === 1'b1 && i_wb_ready === 1'b1)
      begin
        chk(o_wb_word === gold[nw*WORD_W +: WORD_W], "write-back word");
        nw++;
      end
      i_gold_valid = (o_fetch_req === 1'b1 && ng < FRAME_WORDS);
      i_gold_word = i_gold_valid ? gold[ng*WORD_W +: WORD_W] : ~i_gold_word;
      if (i_gold_valid)
        ng++;
      cyc++;
      @(negedge i_core_clk);
    end
    i_gold_valid = 1'b0;
    @(negedge i_core_clk);
    for (int k = 0; k < 8 && o_rb_halt !== 1'b0; k++)
      @(negedge i_core_clk);
    chk(o_rb_halt === 1'b0, "halt stuck");
    chk(nw == ((es != '0) ? FRAME_WORDS : 0), "write-back count");
    chk(o_frame_addr === ad + 1, "frame address");
    chk((ng == FRAME_WORDS) === (b >= 0), "golden fetch");
    if (es != '0)
      chk(o_saved_syn === es, "saved syndrome");
  endtask
  initial
  begin
    #200000;
    n_fail++;
    final_report();
  end
  initial
  begin
    h = '0;
    for (int i = 0; i < FRAME_BITS; i++)
    begin
      gold[i] = (i < 640 || i > 651) && ((i % 7 == 3) ^ (i % 11 == 0));
      if (gold[i])
        h ^= loc(i);
    end
    gold[650:640] = h;
    gold[651] = 1'b0;
    gold[651] = ^gold;
    repeat (4) @(negedge i_core_clk);
    chk(lnk.done === 1'b0 && o_rb_halt === 1'b0 && o_busy === 1'b0, "reset values");
    i_rst_n = 1'b1;
    i_addr_load = 1'b1;
    i_addr_start = 32'h0000_0100;
    @(negedge i_core_clk);
    i_addr_load = 1'b0;
    @(negedge i_core_clk);
    chk(o_frame_addr === 32'h0000_0100, "address load");
    for (int c = 0; c < 12; c++)
      run(ca[c], cb[c]);
    send(gold, 10);
    chk(o_busy === 1'b1, "busy mid-frame");
    i_rb_abort = 1'b1;
    @(negedge i_core_clk);
    i_rb_abort = 1'b0;
    @(negedge i_core_clk);
    chk(o_busy === 1'b0, "busy after abort");
    run(-1, -1);
    chk(o_frames_checked === 16'h000D, "frames checked");
    chk(o_frames_bad === 16'h000B, "frames bad");
    final_report();
  end
endmodule // tb_top
